//--- hw/stg_pkg.sv
// types shared by the station timing generator
// assumes nothing beyond a systemverilog compiler
package stg_pkg;

	typedef enum logic [1:0] {
		STG_RUN = 2'b00,
		STG_ARMED = 2'b01,
		STG_WAIT = 2'b10
	} stg_sync_state_type;

endpackage : stg_pkg

//--- hw/stg_regs.svh
// register offsets, field positions, reset values and timing counts for the station timing generator
// assumes a 32-bit apb slave clocked by pclk at 125 mhz; included by its bare name
`ifndef STG_REGS_SVH
`define STG_REGS_SVH

`define STG_ADDR_CTRL 12'h000
`define STG_ADDR_STATUS 12'h004
`define STG_ADDR_FRAME 12'h008

`define STG_CTRL_PATTERN 0
`define STG_CTRL_DUAL 1
`define STG_CTRL_FALLING 2
`define STG_CTRL_ARM 3
`define STG_CTRL_RESET 4'h0

`define STG_ST_VALID 0
`define STG_ST_ACTIVE 1
`define STG_ST_RUNNING 2
`define STG_ST_REF 3

`define STG_PCLK_MHZ 125
`define STG_REF_MISS_NS 600
`define STG_REF_MISS_CYC ((`STG_REF_MISS_NS * `STG_PCLK_MHZ + 999) / 1000)

`define STG_DIV60_LONG 66667
`define STG_DIV60_SHORT 66666
`define STG_FRAMES 60
`define STG_TC_DIV 1042
`define STG_AUX_DIV 20
`define STG_STRETCH 400
`define STG_ACT_WINDOW 1024
`define STG_LFSR_SEED 4'h1

`endif

//--- hw/stg_timing_generator.sv
// station timing generator: 60 hz frame timing, seconds tick, time-code and aux clocks,
// test pattern, data samplers with activity check and a missed-reference detector.
// assumes apb master on pclk (125 mhz); oscillator, reference, sync and data pins are async.
`timescale 1ns/1ps
`include "stg_regs.svh"

module stg_timing_generator import stg_pkg::*; #(
	parameter int DIV60_LONG = `STG_DIV60_LONG,
	parameter int DIV60_SHORT = `STG_DIV60_SHORT,
	parameter int FRAMES = `STG_FRAMES,
	parameter int TC_DIV = `STG_TC_DIV,
	parameter int AUX_DIV = `STG_AUX_DIV,
	parameter int STRETCH = `STG_STRETCH,
	parameter int ACT_WINDOW = `STG_ACT_WINDOW
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic osc_8mhz,
	input wire logic ref_5mhz,
	input wire logic sync_in,
	input wire logic sample_a,
	input wire logic sample_b,
	output logic tick_60hz,
	output logic tick_1hz,
	output logic square_1hz,
	output logic stretch_1hz,
	output logic stretch_60hz,
	output logic timecode_clk,
	output logic aux_clk,
	output logic data_out,
	output logic time_valid,
	output logic data_active
);

	localparam int P_B = 0;
	localparam int P_A = 1;
	localparam int P_SYNC = 2;
	localparam int P_REF = 3;
	localparam int P_OSC = 4;
	localparam logic [16:0] LONG_M1 = 17'(DIV60_LONG - 1);
	localparam logic [16:0] SHORT_M1 = 17'(DIV60_SHORT - 1);
	localparam logic [5:0] LAST_FRAME = 6'(FRAMES - 1);
	localparam logic [5:0] SQ_START = 6'(FRAMES - FRAMES / 4);
	localparam logic [10:0] TC_LAST = 11'(TC_DIV - 1);
	localparam logic [10:0] TC_HALF = 11'(TC_DIV / 2);
	localparam logic [4:0] AUX_LAST = 5'(AUX_DIV - 1);
	localparam logic [4:0] AUX_HALF = 5'(AUX_DIV / 2);
	localparam logic [15:0] STRETCH_LEN = 16'(STRETCH);
	localparam logic [15:0] ACT_LAST = 16'(ACT_WINDOW - 1);
	localparam logic [7:0] REF_MISS = 8'(`STG_REF_MISS_CYC);

	// apb slave
	logic [3:0] ctrl;
	logic [31:0] rd_mux;
	wire acc = psel & penable & ~pready;
	wire done = psel & penable & pready;
	wire hit_ctrl = paddr == `STG_ADDR_CTRL;
	wire hit_status = paddr == `STG_ADDR_STATUS;
	wire hit_frame = paddr == `STG_ADDR_FRAME;
	wire mapped = hit_ctrl | hit_status | hit_frame;
	wire pattern_sel = ctrl[`STG_CTRL_PATTERN];
	wire dual_mode = ctrl[`STG_CTRL_DUAL];
	wire sync_falling = ctrl[`STG_CTRL_FALLING];
	wire sync_arm = ctrl[`STG_CTRL_ARM];

	// pin synchronisers; only the second stage and its delayed copy feed logic
	logic [4:0] pin_meta;
	logic [4:0] pin_sync;
	logic [4:0] pin_prev;
	wire [4:0] pin_raw = {osc_8mhz, ref_5mhz, sync_in, sample_a, sample_b};
	wire [4:0] pin_rise = pin_sync & ~pin_prev;
	wire [4:0] pin_fall = ~pin_sync & pin_prev;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_meta <= 5'h00;
			pin_sync <= 5'h00;
			pin_prev <= 5'h00;
		end else begin
			pin_meta <= pin_raw;
			pin_sync <= pin_meta;
			pin_prev <= pin_sync;
		end
	end

	// 4 mhz strobe: every second rising edge of the 8 mhz oscillator
	logic half;
	logic en4;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			half <= 1'b0;
			en4 <= 1'b0;
		end else begin
			half <= half ^ pin_rise[P_OSC];
			en4 <= pin_rise[P_OSC] & half;
		end
	end

	// sync arm sequence
	stg_sync_state_type state;
	stg_sync_state_type next_state;
	wire edge_match = sync_falling ? pin_fall[P_SYNC] : pin_rise[P_SYNC];
	wire run = state == STG_RUN;
	wire start = (state == STG_WAIT) & ~sync_arm & edge_match;

	always_comb begin
		next_state = state;
		case (state)
			STG_RUN: begin
				if (sync_arm) next_state = STG_ARMED;
			end
			STG_ARMED: begin
				if (!sync_arm) next_state = STG_WAIT;
			end
			STG_WAIT: begin
				if (sync_arm) next_state = STG_ARMED;
				else if (edge_match) next_state = STG_RUN;
			end
			default: begin
				next_state = STG_RUN;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) state <= STG_RUN;
		else state <= next_state;
	end

	// 60 hz divider and frame count; while stopped the counters sit one strobe before
	// a seconds tick, so a start puts the tick within one 4 mhz cycle of the sync edge
	logic [16:0] cnt60;
	logic [1:0] phase;
	logic [5:0] frame;
	wire at_term = cnt60 == 17'h00000;
	wire term60 = run & en4 & at_term;
	wire at_last = frame == LAST_FRAME;
	wire sec_now = term60 & at_last;
	wire [5:0] next_frame = at_last ? 6'h00 : frame + 6'h01;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt60 <= 17'h00000;
			phase <= 2'h0;
		end else if (!run) begin
			cnt60 <= 17'h00000;
			phase <= 2'h0;
		end else if (en4) begin
			cnt60 <= at_term ? ((phase == 2'h2) ? SHORT_M1 : LONG_M1) : cnt60 - 17'h00001;
			if (at_term) phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) frame <= 6'h00;
		else if (!run) frame <= LAST_FRAME;
		else if (term60) frame <= next_frame;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_60hz <= 1'b0;
			tick_1hz <= 1'b0;
			square_1hz <= 1'b0;
		end else if (!run) begin
			tick_60hz <= 1'b0;
			tick_1hz <= 1'b0;
			square_1hz <= 1'b0;
		end else if (en4) begin
			tick_60hz <= at_term;
			tick_1hz <= at_term & at_last;
			if (at_term) square_1hz <= next_frame >= SQ_START;
		end
	end

	// stretched ticks for the display clock, one per tick kind
	logic [1:0] stretch_q;
	wire [1:0] stretch_trig = {term60, sec_now};

	genvar gi;
	generate
		for (gi = 0; gi < 2; gi++) begin : g_stretch
			logic [15:0] left;
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					left <= 16'h0000;
					stretch_q[gi] <= 1'b0;
				end else if (stretch_trig[gi]) begin
					left <= STRETCH_LEN;
					stretch_q[gi] <= 1'b1;
				end else if (en4 && left != 16'h0000) begin
					left <= left - 16'h0001;
					if (left == 16'h0001) stretch_q[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	assign stretch_1hz = stretch_q[0];
	assign stretch_60hz = stretch_q[1];

	// time-code and auxiliary dividers
	logic [10:0] tc_cnt;
	logic [4:0] aux_cnt;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) tc_cnt <= 11'h000;
		else if (!run || term60) tc_cnt <= 11'h000;
		else if (en4) tc_cnt <= (tc_cnt == TC_LAST) ? 11'h000 : tc_cnt + 11'h001;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) aux_cnt <= 5'h00;
		else if (!run) aux_cnt <= 5'h00;
		else if (en4) aux_cnt <= (aux_cnt == AUX_LAST) ? 5'h00 : aux_cnt + 5'h01;
	end

	// one pclk of lag against the counters is accepted to keep the outputs registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timecode_clk <= 1'b0;
			aux_clk <= 1'b0;
		end else begin
			timecode_clk <= run & (tc_cnt < TC_HALF);
			aux_clk <= run & (aux_cnt < AUX_HALF);
		end
	end

	// test pattern: x^4 + x^3 + 1, period fifteen
	logic [3:0] lfsr;
	// the tick's own slot carries the first pattern bit, so every frame matches bit for bit
	wire [3:0] lfsr_cur = term60 ? `STG_LFSR_SEED : lfsr;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) lfsr <= `STG_LFSR_SEED;
		else if (!run) lfsr <= `STG_LFSR_SEED;
		else if (en4) lfsr <= {lfsr_cur[2:0], lfsr_cur[3] ^ lfsr_cur[2]};
	end

	// samplers: single mode takes input a every strobe, dual mode alternates a and b
	logic slot;
	wire take_b = dual_mode & slot;
	wire [1:0] smp_stb = {en4 & take_b, en4 & ~take_b};
	wire [1:0] smp_pin = {pin_sync[P_B], pin_sync[P_A]};
	wire sample_now = take_b ? pin_sync[P_B] : pin_sync[P_A];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			slot <= 1'b0;
			data_out <= 1'b0;
		end else if (en4) begin
			slot <= dual_mode & ~slot;
			data_out <= pattern_sel ? lfsr_cur[3] : sample_now;
		end
	end

	// activity check over a window of strobes
	logic [15:0] act_cnt;
	logic [1:0] seen0;
	logic [1:0] seen1;
	wire act_end = en4 & (act_cnt == ACT_LAST);
	wire [1:0] busy = seen0 & seen1;

	generate
		for (gi = 0; gi < 2; gi++) begin : g_act
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					seen0[gi] <= 1'b0;
					seen1[gi] <= 1'b0;
				end else begin
					if (act_end) begin
						seen0[gi] <= 1'b0;
						seen1[gi] <= 1'b0;
					end else if (smp_stb[gi]) begin
						seen0[gi] <= seen0[gi] | ~smp_pin[gi];
						seen1[gi] <= seen1[gi] | smp_pin[gi];
					end
				end
			end
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			act_cnt <= 16'h0000;
			data_active <= 1'b0;
		end else if (en4) begin
			act_cnt <= (act_cnt == ACT_LAST) ? 16'h0000 : act_cnt + 16'h0001;
			if (act_end) data_active <= busy[0] & (busy[1] | ~dual_mode);
		end
	end

	// missed reference: no 5 mhz rising edge for about three of its periods
	logic [7:0] ref_cnt;
	wire ref_lost = ref_cnt >= REF_MISS;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) ref_cnt <= 8'h00;
		else if (pin_rise[P_REF]) ref_cnt <= 8'h00;
		else if (!ref_lost) ref_cnt <= ref_cnt + 8'h01;
	end

	// time valid: only a completed sync arm sequence can set it again
	logic valid_pending;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) valid_pending <= 1'b0;
		else if (start) valid_pending <= 1'b1;
		else if (!run) valid_pending <= 1'b0;
		else if (sec_now) valid_pending <= 1'b0;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) time_valid <= 1'b0;
		else if (!run || ref_lost) time_valid <= 1'b0;
		else if (sec_now && valid_pending) time_valid <= 1'b1;
	end

	// register reads and writes; every access takes one wait cycle
	always_comb begin
		rd_mux = 32'h00000000;
		if (hit_ctrl) rd_mux[3:0] = ctrl;
		if (hit_status) begin
			rd_mux[`STG_ST_VALID] = time_valid;
			rd_mux[`STG_ST_ACTIVE] = data_active;
			rd_mux[`STG_ST_RUNNING] = run;
			rd_mux[`STG_ST_REF] = ~ref_lost;
		end
		if (hit_frame) rd_mux[5:0] = frame;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= acc;
			pslverr <= acc & ~mapped;
			prdata <= (acc & ~pwrite) ? rd_mux : 32'h00000000;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) ctrl <= `STG_CTRL_RESET;
		else if (done && pwrite && hit_ctrl) ctrl <= pwdata[3:0];
	end

endmodule : stg_timing_generator

//--- testbench/stg_station_model.sv
// far side: 8 mhz oscillator, 5 mhz reference and a frame counter
// assumes the bench gates the reference with ref_on
`timescale 1ns/1ps
module stg_station_model (
	input wire logic ref_on,
	input wire logic tick_60hz,
	output logic osc_8mhz,
	output logic ref_5mhz,
	output int frames
);
	initial begin
		osc_8mhz = 1'b0;
		ref_5mhz = 1'b0;
		frames = 0;
	end
	// phase unrelated to pclk, so strobe spacing jitters
	always #62.5 osc_8mhz = ~osc_8mhz;
	// a dead standard freezes rather than idling
	always #100 ref_5mhz = ref_on ? ~ref_5mhz : ref_5mhz;
	always @(posedge tick_60hz) frames = frames + 1;
endmodule : stg_station_model

//--- testbench/stg_timing_generator_chk.sv
// checker: tick, square, stretch and valid relations at the generator pins
// assumes binding to stg_timing_generator from the bench top
`timescale 1ns/1ps
module stg_chk (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ref_5mhz,
	input wire logic tick_60hz,
	input wire logic tick_1hz,
	input wire logic square_1hz,
	input wire logic stretch_1hz,
	input wire logic stretch_60hz,
	input wire logic timecode_clk,
	input wire logic time_valid
);
	logic ref_d;
	logic [7:0] quiet;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// pclk since the reference last moved; saturates
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_d <= 1'b0;
			quiet <= 8'h00;
		end else begin
			ref_d <= ref_5mhz;
			quiet <= (ref_5mhz != ref_d) ? 8'h00 : quiet + {7'h00, quiet != 8'hff};
		end
	end
	chk_sec_in_frame: assert property (tick_1hz |-> tick_60hz)
		else $error("sec off frame");
	chk_tick_width: assert property ($rose(tick_60hz) |-> tick_60hz[*8] ##30 !tick_60hz)
		else $error("tick width");
	chk_square_fall: assert property ($rose(tick_1hz) |-> !square_1hz)
		else $error("square late");
	chk_stretch_frame: assert property ($rose(tick_60hz) |-> ##40 stretch_60hz)
		else $error("stretch 60");
	chk_stretch_sec: assert property ($rose(tick_1hz) |-> ##40 stretch_1hz)
		else $error("stretch 1");
	chk_valid_at_sec: assert property ($rose(time_valid) |-> tick_1hz)
		else $error("valid off sec");
	chk_ref_loss: assert property (quiet > 8'd120 |-> !time_valid)
		else $error("valid w/o ref");
	chk_tc_restart: assert property ($rose(tick_60hz) |-> ##[0:2] timecode_clk)
		else $error("tc not reset");
endmodule : stg_chk

//--- testbench/stg_timing_generator_tb_top.sv
// bench top: apb master, sync, pattern and sampler checks
// assumes shortened dividers; station model makes osc and reference
`timescale 1ns/1ps
`include "stg_regs.svh"
module stg_timing_generator_tb_top;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic ref_on = 1'b1, sync_in = 1'b0, sample_a = 1'b0, sample_b = 1'b0, err, pol;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [29:0] bits;
	logic [14:0] pat;
	logic [4:0] mode = 5'h00;
	logic [4:0] cases [5] = '{5'h02, 5'h08, 5'h12, 5'h18, 5'h1c};
	logic pready, pslverr, osc_8mhz, ref_5mhz, tick_60hz, tick_1hz, square_1hz;
	logic stretch_1hz, stretch_60hz, timecode_clk, aux_clk, data_out, time_valid, data_active;
	int errors = 0, n_compared = 0, frames, f0, k, acc, gap;
	realtime t0;
	always #4 pclk = ~pclk;
	// mode: dual, a random, b random, a level, b level
	always @(posedge pclk) begin
		sample_a <= mode[3] ? 1'($urandom) : mode[1];
		sample_b <= mode[2] ? 1'($urandom) : mode[0];
	end
	stg_timing_generator #(.DIV60_LONG(67), .DIV60_SHORT(66), .FRAMES(8), .TC_DIV(10),
		.ACT_WINDOW(16)) stg_timing_generator_i (.pclk, .presetn, .psel,
		.penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .osc_8mhz,
		.ref_5mhz, .sync_in, .sample_a, .sample_b, .tick_60hz, .tick_1hz, .square_1hz,
		.stretch_1hz, .stretch_60hz, .timecode_clk, .aux_clk, .data_out, .time_valid,
		.data_active);
	stg_station_model stg_station_model_i (.ref_on, .tick_60hz, .osc_8mhz, .ref_5mhz,
		.frames);
	task automatic test_done();
		if (errors == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : test_done
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic wt(ref logic s, input logic v, input int lim);
		for (int i = 0; i < lim && s !== v; i++) begin
			@(posedge pclk);
			#1;
		end
		if (s !== v) begin
			chk("wait", 32'(s), 32'(v));
			test_done();
		end
	endtask : wt
	function automatic logic [31:0] exp_act(logic [4:0] m);
		return 32'(m[3] && (!m[4] || m[2]));
	endfunction : exp_act
	// stretched seconds tick stands for the stretch length in strobes after a seconds tick
	function automatic logic [31:0] exp_st(int k, int acc);
		return {30'h0, 1'b1, k == 7 || acc < `STG_STRETCH};
	endfunction : exp_st
	// time to level v, in 4 mhz periods
	task automatic span(ref logic s, input logic v, input int n, input string nm);
		t0 = $realtime;
		wt(s, v, 3000);
		chk(nm, 32'(int'(($realtime - t0) / 250.0)), 32'(n));
	endtask : span
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (int i = 0; i < 16 && pready !== 1'b1; i++)
			@(posedge pclk);
		if (pready !== 1'b1) begin
			chk("pready", 32'(pready), 32'h1);
			test_done();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// sample mid-period from a frame tick on
	task automatic grab(input int cnt);
		wt(tick_60hz, 1'b0, 3000);
		wt(tick_60hz, 1'b1, 3000);
		#124;
		for (int i = 0; i < cnt; i++) begin
			bits[i] = data_out;
			#250;
		end
	endtask : grab
	initial begin
		void'($urandom(32'h3870a99f));
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		repeat (100) @(posedge pclk);
		apb(1'b0, 12'h000, 32'h0);
		chk("ctrl", rd, 32'h0);
		apb(1'b0, 12'h00c, 32'h0);
		chk("slverr", 32'(err), 32'h1);
		apb(1'b0, 12'h004, 32'h0);
		chk("ref", 32'(rd[3]), 32'h1);
		pol = 1'($urandom);
		sync_in <= ~pol;
		apb(1'b1, 12'h000, {28'h1, pol, 2'b00});
		repeat (40) @(posedge pclk);
		apb(1'b0, 12'h004, 32'h0);
		chk("armed", rd & 32'h5, 32'h0);
		chk("stop", 32'({tick_60hz, aux_clk, timecode_clk}), 32'h0);
		apb(1'b1, 12'h000, {29'h0, pol, 2'b00});
		sync_in <= pol;
		repeat (40) @(posedge pclk);
		chk("held", 32'({tick_60hz, aux_clk}), 32'h0);
		sync_in <= ~pol;
		t0 = $realtime;
		wt(tick_60hz, 1'b1, 100);
		chk("lag", 32'($realtime - t0 < 320.0), 32'h1);
		chk("first", 32'({tick_1hz, time_valid}), 32'h3);
		f0 = frames;
		acc = 0;
		for (k = 0; k < 8; k++) begin
			gap = (k % 3 == 2) ? 66 : 67;
			acc += gap;
			wt(tick_60hz, 1'b0, 100);
			// timed from the tick's fall, so one strobe short of the period
			span(tick_60hz, 1'b1, gap - 1, "gap");
			chk("sec", 32'(tick_1hz), 32'(k == 7));
			#17;
			chk("sq", 32'(square_1hz), 32'(k == 5 || k == 6));
			chk("st", 32'({stretch_60hz, stretch_1hz}), exp_st(k, acc));
		end
		chk("frames", 32'(frames - f0), 32'h8);
		wt(timecode_clk, 1'b0, 300);
		span(timecode_clk, 1'b1, 5, "tc");
		wt(aux_clk, 1'b0, 800);
		span(aux_clk, 1'b1, 10, "aux_lo");
		span(aux_clk, 1'b0, 10, "aux_hi");
		apb(1'b1, 12'h000, {29'h0, pol, 2'b01});
		grab(30);
		chk("rep", 32'(bits[29:15]), 32'(bits[14:0]));
		chk("ones", 32'($countones(bits[14:0])), 32'h8);
		pat = bits[14:0];
		grab(15);
		chk("frame", 32'(bits[14:0]), 32'(pat));
		for (k = 0; k < 5; k++) begin
			mode <= cases[k];
			apb(1'b1, 12'h000, {29'h0, pol, cases[k][4], 1'b0});
			#12000;
			chk("act", 32'(data_active), exp_act(cases[k]));
			grab(2);
			if (!cases[k][3])
				chk("alt", 32'(bits[0] ^ bits[1]), 32'(cases[k][4]));
			if (cases[k][4:3] == 2'b00)
				chk("lvl", 32'(bits[0]), 32'(cases[k][1]));
		end
		chk("valid", 32'(time_valid), 32'h1);
		ref_on <= 1'b0;
		#1000;
		apb(1'b0, 12'h004, 32'h0);
		chk("drop", rd & 32'h9, 32'h0);
		ref_on <= 1'b1;
		wt(tick_1hz, 1'b1, 20000);
		#17;
		chk("stay", 32'(time_valid), 32'h0);
		test_done();
	end
endmodule : stg_timing_generator_tb_top
bind stg_timing_generator stg_chk stg_chk_i (.pclk, .presetn, .ref_5mhz, .tick_60hz,
	.tick_1hz, .square_1hz, .stretch_1hz, .stretch_60hz, .timecode_clk, .time_valid);
